// file: dmsa_defs.svh
// constants for data memory sector addressing
`ifndef DMSA_DEFS_SVH
`define DMSA_DEFS_SVH
`define DMSA_OFS_WINDOW_SECTOR0 8'h00
`define DMSA_OFS_POINTER_SECTOR0 8'h01
`define DMSA_OFS_WINDOW_ONE 8'h02
`define DMSA_OFS_POINTER_ONE_LOW 8'h03
`define DMSA_OFS_POINTER_ONE_SECTOR 8'h04
`define DMSA_OFS_WINDOW_TWO 8'h0c
`define DMSA_OFS_POINTER_TWO_LOW 8'h0d
`define DMSA_OFS_POINTER_TWO_SECTOR 8'h0e
`define DMSA_SPECIAL_LAST 8'h7f
`define DMSA_GP_FIRST 8'h80
`define DMSA_ZERO_BYTE 8'h00
`define DMSA_PTR_RESET 8'h00
`define DMSA_SECTOR_COUNT 16
`define DMSA_SECTOR_BITS 4
`define DMSA_EXT_ADDR_BITS 12
`endif

// file: dmsa_pkg.sv
// types for data memory sector addressing
`include "dmsa_defs.svh"
package dmsa_pkg;
   typedef logic [7:0] dmsa_byte_t;
   typedef logic [`DMSA_EXT_ADDR_BITS-1:0] dmsa_addr_t;
   typedef logic [`DMSA_SECTOR_BITS-1:0] dmsa_sector_t;
   typedef enum logic [1:0] {DMSA_REGION_RAM, DMSA_REGION_SPECIAL, DMSA_REGION_POINTER, DMSA_REGION_WINDOW}
      dmsa_region_e;
endpackage : dmsa_pkg

// file: dmsa_resolve.sv
// combinational window-to-pointer address resolution
`timescale 1ns/100ps
`include "dmsa_defs.svh"
module dmsa_resolve
   import dmsa_pkg::*;
(
   // access
   input wire dmsa_pkg::dmsa_addr_t addr,
   // pointers
   input wire dmsa_pkg::dmsa_byte_t ptr0,
   input wire dmsa_pkg::dmsa_byte_t ptr1_low,
   input wire dmsa_pkg::dmsa_byte_t ptr1_sector,
   input wire dmsa_pkg::dmsa_byte_t ptr2_low,
   input wire dmsa_pkg::dmsa_byte_t ptr2_sector,
   // result
   output dmsa_pkg::dmsa_addr_t eff_addr
);
   always_comb begin
      eff_addr = addr;
      if (addr[11:8] == '0) begin
         case (addr[7:0])
            `DMSA_OFS_WINDOW_SECTOR0: eff_addr = {4'h0, ptr0};
            `DMSA_OFS_WINDOW_ONE: eff_addr = {ptr1_sector[3:0], ptr1_low};
            `DMSA_OFS_WINDOW_TWO: eff_addr = {ptr2_sector[3:0], ptr2_low};
            default: eff_addr = addr;
         endcase
      end
   end
endmodule : dmsa_resolve

// file: dmsa_classify.sv
// region decode of a resolved address
`timescale 1ns/100ps
`include "dmsa_defs.svh"
module dmsa_classify
   import dmsa_pkg::*;
(
   // address
   input wire dmsa_pkg::dmsa_addr_t addr,
   // region
   output dmsa_pkg::dmsa_region_e region
);
   always_comb begin
      if (addr[7:0] >= `DMSA_GP_FIRST) begin
         region = DMSA_REGION_RAM;
      end else if (addr[11:8] != '0) begin
         region = DMSA_REGION_SPECIAL;
      end else begin
         case (addr[7:0])
            `DMSA_OFS_WINDOW_SECTOR0, `DMSA_OFS_WINDOW_ONE, `DMSA_OFS_WINDOW_TWO: region = DMSA_REGION_WINDOW;
            `DMSA_OFS_POINTER_SECTOR0, `DMSA_OFS_POINTER_ONE_LOW, `DMSA_OFS_POINTER_ONE_SECTOR,
            `DMSA_OFS_POINTER_TWO_LOW, `DMSA_OFS_POINTER_TWO_SECTOR: region = DMSA_REGION_POINTER;
            default: region = DMSA_REGION_SPECIAL;
         endcase
      end
   end
endmodule : dmsa_classify

// file: dmsa_top.sv
// data memory sector decoder with pointers, windows and general RAM
// Notes on behaviour
// - offsets 00h to 7fh of each sector decode to special registers, except the pointers and windows of sector 0
// - offsets 80h to ffh of each sector decode to general RAM
// - extended address has 12 bits: high nibble sector, low byte offset
// - direct addressing reaches every sector via the full-width address
// - reads of unimplemented special locations return zero
// - window accesses redirect to the address held in its pointer
// - first window always resolves within sector 0
// - second and third windows take sector from pointer high byte
// - second and third windows take offset from pointer low byte
// - a window resolving to a window reads zero, writes nothing
// - five pointers are real read/write storage
// - no bank select; program bank pointer ignored by data decode
// - bit set/clear change one RAM bit, others kept
// - protected special locations read only; writes ignored
`timescale 1ns/100ps
`include "dmsa_defs.svh"
module dmsa_top
   import dmsa_pkg::*;
#(
   parameter int SECTORS = `DMSA_SECTOR_COUNT
)(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // core access
   input wire logic ACC_EN,
   input wire logic ACC_WR,
   input wire dmsa_pkg::dmsa_addr_t ACC_ADDR,
   input wire dmsa_pkg::dmsa_byte_t ACC_WDATA,
   input wire logic ACC_BIT_OP,
   input wire logic ACC_BIT_VAL,
   input wire logic [2:0] ACC_BIT_SEL,
   // program bank pointer, not used for data
   input wire logic PROGRAM_BANK_SELECT,
   // external special register file
   input wire dmsa_pkg::dmsa_byte_t SFR_RDATA,
   input wire logic SFR_PRESENT,
   input wire logic SFR_PROTECTED,
   output dmsa_pkg::dmsa_addr_t SFR_ADDR,
   output dmsa_pkg::dmsa_byte_t SFR_WDATA,
   output logic SFR_WE,
   // answer
   output dmsa_pkg::dmsa_byte_t ACC_RDATA,
   output logic ACC_VALID
);
   if (SECTORS < 1 || SECTORS > `DMSA_SECTOR_COUNT) begin : g_bad_sectors
      $error("dmsa_top: SECTORS out of range");
   end

   typedef struct packed {
      dmsa_byte_t ptr0;
      dmsa_byte_t ptr1_low;
      dmsa_byte_t ptr1_sector;
      dmsa_byte_t ptr2_low;
      dmsa_byte_t ptr2_sector;
      dmsa_addr_t sfr_addr;
      dmsa_byte_t sfr_wdata;
      logic sfr_we;
      dmsa_byte_t rdata;
      logic valid;
      logic pend_sfr;
      logic pend_wr;
   } dmsa_state_s;

   dmsa_state_s st_reg;
   dmsa_state_s st_next;
   dmsa_byte_t ram [SECTORS*128];
   dmsa_byte_t ram_q;
   logic ram_we;
   logic [10:0] ram_idx;
   dmsa_byte_t ram_wbyte;
   dmsa_addr_t eff_addr;
   dmsa_region_e region;
   dmsa_byte_t old_byte;
   dmsa_byte_t new_byte;
   logic in_range;

   dmsa_resolve u_resolve (
      .addr(ACC_ADDR),
      .ptr0(st_reg.ptr0),
      .ptr1_low(st_reg.ptr1_low),
      .ptr1_sector(st_reg.ptr1_sector),
      .ptr2_low(st_reg.ptr2_low),
      .ptr2_sector(st_reg.ptr2_sector),
      .eff_addr(eff_addr)
   );

   dmsa_classify u_classify (
      .addr(eff_addr),
      .region(region)
   );

   // only four sector bits decode; sectors beyond SECTORS are not RAM
   assign in_range = int'(eff_addr[11:8]) < SECTORS;
   assign ram_idx = {eff_addr[11:8], eff_addr[6:0]};

   always_comb begin
      old_byte = `DMSA_ZERO_BYTE;
      case (eff_addr[7:0])
         `DMSA_OFS_POINTER_SECTOR0: old_byte = st_reg.ptr0;
         `DMSA_OFS_POINTER_ONE_LOW: old_byte = st_reg.ptr1_low;
         `DMSA_OFS_POINTER_ONE_SECTOR: old_byte = st_reg.ptr1_sector;
         `DMSA_OFS_POINTER_TWO_LOW: old_byte = st_reg.ptr2_low;
         `DMSA_OFS_POINTER_TWO_SECTOR: old_byte = st_reg.ptr2_sector;
         default: old_byte = `DMSA_ZERO_BYTE;
      endcase
      if (region == DMSA_REGION_RAM) begin
         old_byte = ram[ram_idx];
      end
      new_byte = ACC_WDATA;
      if (ACC_BIT_OP) begin
         new_byte = old_byte;
         new_byte[ACC_BIT_SEL] = ACC_BIT_VAL;
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      st_next.sfr_we = 1'b0;
      st_next.pend_sfr = 1'b0;
      st_next.pend_wr = 1'b0;
      ram_we = 1'b0;
      ram_wbyte = new_byte;
      // protection is only known once the address stands on SFR_ADDR, so the strobe waits a cycle
      // limitation: one access in flight; the core waits for ACC_VALID before its next request
      if (st_reg.pend_sfr) begin
         st_next.rdata = SFR_PRESENT ? SFR_RDATA : `DMSA_ZERO_BYTE;
         st_next.valid = 1'b1;
         st_next.sfr_we = st_reg.pend_wr && !SFR_PROTECTED;
      end
      if (ACC_EN) begin
         st_next.valid = 1'b1;
         st_next.rdata = `DMSA_ZERO_BYTE;
         case (region)
            DMSA_REGION_RAM: begin
               if (in_range) begin
                  st_next.rdata = old_byte;
                  ram_we = ACC_WR;
               end
            end
            DMSA_REGION_POINTER: begin
               st_next.rdata = old_byte;
               if (ACC_WR) begin
                  case (eff_addr[7:0])
                     `DMSA_OFS_POINTER_SECTOR0: st_next.ptr0 = new_byte;
                     `DMSA_OFS_POINTER_ONE_LOW: st_next.ptr1_low = new_byte;
                     `DMSA_OFS_POINTER_ONE_SECTOR: st_next.ptr1_sector = new_byte;
                     `DMSA_OFS_POINTER_TWO_LOW: st_next.ptr2_low = new_byte;
                     `DMSA_OFS_POINTER_TWO_SECTOR: st_next.ptr2_sector = new_byte;
                     default: st_next.ptr0 = st_reg.ptr0;
                  endcase
               end
            end
            DMSA_REGION_WINDOW: begin
               st_next.rdata = `DMSA_ZERO_BYTE;
            end
            default: begin
               // special registers live outside; answer one cycle later
               st_next.valid = 1'b0;
               st_next.pend_sfr = 1'b1;
               st_next.sfr_addr = eff_addr;
               st_next.sfr_wdata = ACC_WDATA;
               st_next.pend_wr = ACC_WR;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (ram_we) begin
         ram[ram_idx] <= ram_wbyte;
      end
   end

   assign SFR_ADDR = st_reg.sfr_addr;
   assign SFR_WDATA = st_reg.sfr_wdata;
   assign SFR_WE = st_reg.sfr_we;
   assign ACC_RDATA = st_reg.rdata;
   assign ACC_VALID = st_reg.valid;
endmodule : dmsa_top

// file: dmsa_properties.sv
// port assertions for the data memory sector decoder
`timescale 1ns/100ps
module dmsa_properties
   import dmsa_pkg::*;
#(
   parameter int SECTORS = 16
)(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // core access
   input wire logic ACC_EN,
   input wire logic ACC_WR,
   input wire dmsa_pkg::dmsa_addr_t ACC_ADDR,
   input wire dmsa_pkg::dmsa_byte_t ACC_WDATA,
   // special file
   input wire dmsa_pkg::dmsa_byte_t SFR_RDATA,
   input wire logic SFR_PRESENT,
   input wire logic SFR_PROTECTED,
   input wire dmsa_pkg::dmsa_addr_t SFR_ADDR,
   input wire dmsa_pkg::dmsa_byte_t SFR_WDATA,
   input wire logic SFR_WE,
   // answer
   input wire dmsa_pkg::dmsa_byte_t ACC_RDATA,
   input wire logic ACC_VALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_ram_req; ACC_EN && ACC_ADDR[7]; endsequence
   // sector 0 low offsets hold pointers and windows, so only other sectors are surely special
   sequence s_sfr_req; ACC_EN && !ACC_ADDR[7] && ACC_ADDR[11:8] != 4'h0; endsequence
   sequence s_sfr_rd; s_sfr_req ##0 !ACC_WR; endsequence
   sequence s_sfr_wr; s_sfr_req ##0 ACC_WR; endsequence
   chk_ram_answer: assert property (s_ram_req |=> ACC_VALID) else $error("ram not answered");
   chk_ram_no_sfr: assert property (s_ram_req |=> !SFR_WE) else $error("ram hit special file");
   chk_sfr_timing: assert property (s_sfr_req |=> SFR_ADDR == $past(ACC_ADDR) ##1 ACC_VALID)
      else $error("special access timing");
   // the strobe follows the address by one cycle and is judged by the protection shown for that address
   chk_sfr_write: assert property (s_sfr_wr |=> ##1 (SFR_WE == !$past(SFR_PROTECTED)
      && SFR_WDATA == $past(ACC_WDATA, 2))) else $error("special write lost");
   chk_prot_block: assert property (SFR_WE |-> !SFR_PROTECTED) else $error("protected write");
   chk_unimpl_zero: assert property (s_sfr_rd ##1 !SFR_PRESENT |=> ACC_RDATA == 8'h00) else $error("unused not zero");
   chk_sfr_rdata: assert property (s_sfr_rd ##1 SFR_PRESENT |=> ACC_RDATA == $past(SFR_RDATA))
      else $error("special read data");
   chk_idle_quiet: assert property (!ACC_EN |-> ##2 !SFR_WE) else $error("write without request");
endmodule : dmsa_properties
bind dmsa_top dmsa_properties #(.SECTORS(SECTORS)) dmsa_properties_i (.CLK(CLK), .RST(RST), .ACC_EN(ACC_EN),
   .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_PRESENT(SFR_PRESENT),
   .SFR_PROTECTED(SFR_PROTECTED), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
   .ACC_RDATA(ACC_RDATA), .ACC_VALID(ACC_VALID));

// file: dmsa_sfr_model.sv
// behavioural special register file behind the decoder
`timescale 1ns/100ps
module dmsa_sfr_model
   import dmsa_pkg::*;
(
   // clock and request
   input wire logic clk,
   input wire dmsa_pkg::dmsa_addr_t a,
   input wire dmsa_pkg::dmsa_byte_t d,
   input wire logic we,
   // answer
   output dmsa_pkg::dmsa_byte_t q,
   output logic present,
   output logic prot
);
   dmsa_byte_t mem [0:4095];
   initial begin
      foreach (mem[i]) begin
         mem[i] = 8'h00;
      end
   end
   // offset 2fh left empty, 7fh read only; an empty place answers junk, not zero
   assign present = a[7:0] != 8'h2f;
   assign prot = a[7:0] == 8'h7f;
   assign q = present ? mem[a] : 8'ha5;
   always @(posedge clk) begin
      if (we) begin
         mem[a] <= d;
      end
   end
endmodule : dmsa_sfr_model

// file: test_dmsa_top.sv
// self-checking bench for the data memory sector decoder
`timescale 1ns/100ps
module test_dmsa_top;
   import dmsa_pkg::*;
   logic clk, rst, acc_en, acc_wr, bit_op, bit_val, bank, present, prot, sfr_we, valid;
   logic [2:0] bit_sel;
   dmsa_addr_t addr, sfr_addr;
   dmsa_byte_t wdata, rdata, sfr_rdata, sfr_wdata, rd;
   int errors = 0;
   int n_tests = 0;
   dmsa_top #(.SECTORS(16)) dmsa_top_i (.CLK(clk), .RST(rst), .ACC_EN(acc_en), .ACC_WR(acc_wr), .ACC_ADDR(addr),
      .ACC_WDATA(wdata), .ACC_BIT_OP(bit_op), .ACC_BIT_VAL(bit_val), .ACC_BIT_SEL(bit_sel),
      .PROGRAM_BANK_SELECT(bank), .SFR_RDATA(sfr_rdata), .SFR_PRESENT(present), .SFR_PROTECTED(prot),
      .SFR_ADDR(sfr_addr), .SFR_WDATA(sfr_wdata), .SFR_WE(sfr_we), .ACC_RDATA(rdata), .ACC_VALID(valid));
   dmsa_sfr_model dmsa_sfr_model_i (.clk(clk), .a(sfr_addr), .d(sfr_wdata), .we(sfr_we), .q(sfr_rdata),
      .present(present), .prot(prot));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input dmsa_byte_t got, input dmsa_byte_t exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // one access from a falling edge; bop is {bit op, bit value, bit select}
   task automatic acc(input logic wr, input dmsa_addr_t a, input dmsa_byte_t d, input logic [4:0] bop);
      int i;
      acc_en = 1'b1;
      acc_wr = wr;
      addr = a;
      wdata = d;
      {bit_op, bit_val, bit_sel} = bop;
      for (i = 0; i < 4; i++) begin
         @(negedge clk);
         if (i == 0) begin
            acc_en = 1'b0;
         end
         if (valid === 1'b1) break;
      end
      if (i == 4) begin
         errors++;
         $display("[FAIL] %0t no answer", $time);
         report_and_stop();
      end else begin
         rd = rdata;
         // one idle edge between accesses, so the strobe is never lowered and raised in one step
         @(negedge clk);
      end
   endtask : acc
   task automatic rdchk(input dmsa_addr_t a, input dmsa_byte_t e);
      acc(1'b0, a, 8'h00, 5'h00);
      check(rd, e);
   endtask : rdchk
   initial begin
      rst = 1'b1;
      {acc_en, acc_wr, bit_op, bit_val, bit_sel, bank} = 8'h00;
      addr = 12'h000;
      wdata = 8'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      rdchk(12'h001, 8'h00);
      acc(1'b1, 12'h001, 8'h85, 5'h00);
      acc(1'b1, 12'h003, 8'h83, 5'h00);
      acc(1'b1, 12'h004, 8'h03, 5'h00);
      acc(1'b1, 12'h00d, 8'h8c, 5'h00);
      acc(1'b1, 12'h00e, 8'h0c, 5'h00);
      rdchk(12'h004, 8'h03);
      rdchk(12'h00d, 8'h8c);
      for (int s = 0; s < 16; s++) begin
         acc(1'b1, {s[3:0], 8'hf0}, 8'h5a ^ s[7:0], 5'h00);
      end
      bank = 1'b1;
      for (int s = 0; s < 16; s++) begin
         rdchk({s[3:0], 8'hf0}, 8'h5a ^ s[7:0]);
      end
      acc(1'b1, 12'h085, 8'h11, 5'h00);
      rdchk(12'h000, 8'h11);
      acc(1'b1, 12'h002, 8'h22, 5'h00);
      rdchk(12'h383, 8'h22);
      acc(1'b1, 12'hc8c, 8'h33, 5'h00);
      rdchk(12'h00c, 8'h33);
      acc(1'b1, 12'h001, 8'h02, 5'h00);
      acc(1'b1, 12'h000, 8'h44, 5'h00);
      rdchk(12'h000, 8'h00);
      rdchk(12'h383, 8'h22);
      acc(1'b1, 12'h1f0, 8'h00, 5'h1a);
      rdchk(12'h1f0, 8'h5f);
      acc(1'b1, 12'h1f0, 8'h00, 5'h10);
      rdchk(12'h1f0, 8'h5e);
      acc(1'b1, 12'h110, 8'h3c, 5'h00);
      rdchk(12'h110, 8'h3c);
      acc(1'b1, 12'h010, 8'h4d, 5'h00);
      rdchk(12'h010, 8'h4d);
      rdchk(12'h12f, 8'h00);
      acc(1'b1, 12'h17f, 8'h99, 5'h00);
      rdchk(12'h17f, 8'h00);
      report_and_stop();
   end
endmodule : test_dmsa_top
